// file: src/eps_serial_out.sv
`timescale 1ns/100ps
`include "eps_params.svh"

// Functional notes
// RL1: Each sample leaves as one 16-bit word, eight X bits and eight Y bits.
// RL2: X byte is sent first, Y byte second.
// RL3: Each coordinate byte goes out least significant bit first.
// RL4: One new bit is launched on each rising edge of the shift clock.
// RL5: Data is valid only while the frame strobe is low; receiver ignores it otherwise.
// RL6: Frame strobe changes only on rising edges of the shift clock.
// RL7: Receiver captures each bit on the clock edge after its launch edge.
// RL8: Strobe low exactly sixteen clock periods per sample, high between samples.

module eps_serial_out (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Sample input
    input wire logic [7:0] sample_x,
    input wire logic [7:0] sample_y,
    input wire logic sample_valid,
    output logic sample_ready,
    // Eye pattern port
    input wire logic eye_shift_clock,
    output logic eye_data,
    output logic eye_frame_strobe_n
);

    logic [1:0] rst_sync_q;
    logic rst_sync_n;

    // Release is synchronised; assertion stays asynchronous
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_sync_n = rst_sync_q[1];

    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [`EPS_WORD_BITS-1:0] fifo_out_data;
    logic fifo_pop;
    logic [`EPS_WORD_BITS-1:0] sample_word;

    // X in the low byte so bit 0 of the word leaves first
    assign sample_word = {sample_y, sample_x}; // RL1 RL2

    eps_fifo #(
        .WIDTH(`EPS_WORD_BITS),
        .DEPTH(`EPS_FIFO_DEPTH)
    ) u_fifo (
        .clk(mclk),
        .rst_n(rst_sync_n),
        .in_valid(sample_valid),
        .in_data(sample_word),
        .in_ready(fifo_in_ready),
        .out_valid(fifo_out_valid),
        .out_data(fifo_out_data),
        .out_ready(fifo_pop)
    );

    eps_pkg::eps_ser_t r_q;
    eps_pkg::eps_ser_t r_d;

    logic clk_stable;
    logic clk_rise;

    always_comb begin
        r_d = r_q;
        fifo_pop = 1'b0;
        r_d.clk_sync = {r_q.clk_sync[1:0], eye_shift_clock};
        // Level accepted only once stages two and three agree
        clk_stable = (r_q.clk_sync[1] == r_q.clk_sync[2]);
        clk_rise = clk_stable && r_q.clk_sync[2] && !r_q.clk_level;
        if (clk_stable) begin
            r_d.clk_level = r_q.clk_sync[2];
        end
        r_d.ready = fifo_in_ready;
        // All strobe and data changes happen only on a clock rise
        if (clk_rise) begin // RL4 RL6
            case (r_q.state)
                eps_pkg::EPS_IDLE: begin
                    if (fifo_out_valid) begin
                        fifo_pop = 1'b1;
                        r_d.shreg = fifo_out_data;
                        r_d.data = fifo_out_data[0]; // RL3
                        r_d.bit_cnt = `EPS_CNT_FIRST;
                        r_d.strobe_n = 1'b0; // RL5
                        r_d.state = eps_pkg::EPS_SHIFT;
                    end
                end
                eps_pkg::EPS_SHIFT: begin
                    if (r_q.bit_cnt == `EPS_CNT_LAST) begin
                        // Raised at the 17th rise; next frame no sooner
                        // than the rise after, so at least one period high
                        r_d.strobe_n = 1'b1; // RL8
                        r_d.data = `EPS_DATA_RST;
                        r_d.state = eps_pkg::EPS_IDLE;
                    end else begin
                        r_d.data = r_q.shreg[r_q.bit_cnt[3:0]]; // RL3 RL4
                        r_d.bit_cnt = r_q.bit_cnt + `EPS_CNT_FIRST;
                    end
                end
                default: begin
                    r_d.state = eps_pkg::EPS_IDLE;
                    r_d.strobe_n = `EPS_STROBE_N_RST;
                    r_d.data = `EPS_DATA_RST;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            r_q.clk_sync <= `EPS_SYNC_RST;
            r_q.clk_level <= 1'b0;
            r_q.state <= eps_pkg::EPS_IDLE;
            r_q.shreg <= 16'h0000;
            r_q.bit_cnt <= 5'h00;
            r_q.data <= `EPS_DATA_RST;
            r_q.strobe_n <= `EPS_STROBE_N_RST;
            r_q.ready <= 1'b0;
        end else begin
            r_q <= r_d;
        end
    end

    // Ready is one cycle behind the buffer; the buffer still guards
    // against overflow, so a late push is simply not taken
    assign sample_ready = r_q.ready;
    assign eye_data = r_q.data; // RL7
    assign eye_frame_strobe_n = r_q.strobe_n;

endmodule

// file: include/eps_params.svh
`ifndef EPS_PARAMS_SVH
`define EPS_PARAMS_SVH

// Serial word layout
`define EPS_AXIS_BITS 8
`define EPS_WORD_BITS 16
`define EPS_X_LSB 0
`define EPS_Y_LSB 8

// Bit counter: width and the count that ends a frame
`define EPS_CNT_W 5
`define EPS_CNT_FIRST 5'h01
`define EPS_CNT_LAST 5'h10

// Sample buffer
`define EPS_FIFO_DEPTH 32

// Reset values
`define EPS_STROBE_N_RST 1'b1
`define EPS_DATA_RST 1'b0
`define EPS_SYNC_RST 3'h0

`endif

// file: include/eps_pkg.sv
package eps_pkg;

    typedef enum logic [1:0] {
        EPS_IDLE  = 2'b01,
        EPS_SHIFT = 2'b10
    } eps_state_t;

    typedef struct packed {
        logic [2:0] clk_sync;
        logic clk_level;
        eps_state_t state;
        logic [15:0] shreg;
        logic [4:0] bit_cnt;
        logic data;
        logic strobe_n;
        logic ready;
    } eps_ser_t;

endpackage

// file: src/eps_fifo.sv
`timescale 1ns/100ps

module eps_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Fill side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // Drain side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);

    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW-1:0] wr_ptr;
        logic [PW-1:0] rd_ptr;
        logic [CW-1:0] count;
        logic in_ready;
        logic out_valid;
    } eps_fifo_t;

    eps_fifo_t r_q;
    eps_fifo_t r_d;

    function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] p);
        if (p == PW'(DEPTH - 1)) begin
            next_ptr = '0;
        end else begin
            next_ptr = p + PW'(1);
        end
    endfunction

    logic push;
    logic pop;

    always_comb begin
        push = in_valid && r_q.in_ready;
        pop = out_ready && r_q.out_valid;
        r_d = r_q;
        if (push) begin
            r_d.mem[r_q.wr_ptr] = in_data;
            r_d.wr_ptr = next_ptr(r_q.wr_ptr);
        end
        if (pop) begin
            r_d.rd_ptr = next_ptr(r_q.rd_ptr);
        end
        r_d.count = r_q.count + CW'(push) - CW'(pop);
        // Flags registered so both handshakes see flop outputs
        r_d.in_ready = (r_d.count != FULL_CNT);
        r_d.out_valid = (r_d.count != '0);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r_q <= '0;
            r_q.in_ready <= 1'b1;
        end else begin
            r_q <= r_d;
        end
    end

    assign in_ready = r_q.in_ready;
    assign out_valid = r_q.out_valid;
    assign out_data = r_q.mem[r_q.rd_ptr];

endmodule

// file: test/eps_eye_rx.sv
`timescale 1ns/100ps
module eps_eye_rx (
    // Eye port, captured word
    input wire logic eye_shift_clock,
    input wire logic eye_data,
    input wire logic eye_frame_strobe_n,
    output logic [15:0] word,
    output int nwords
);
    int cnt;
    // Mid-bit capture; only whole frames count
    always @(negedge eye_shift_clock or posedge eye_frame_strobe_n) begin
        if (eye_frame_strobe_n !== 1'b0) begin
            nwords += int'(cnt == 16);
            cnt = 0;
        end else begin
            word = {eye_data, word[15:1]};
            cnt++;
        end
    end
endmodule

// file: test/eps_serial_out_checker.sv
`timescale 1ns/100ps
module eps_serial_out_checker (
    // Clock, reset and eye port
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic eye_shift_clock,
    input wire logic eye_data,
    input wire logic eye_frame_strobe_n
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic p_q;
    logic [3:0] s_q;
    logic [4:0] n_q;
    wire stb = eye_frame_strobe_n;
    wire rise = eye_shift_clock & ~p_q;
    // Pin is async: a launch lands 2 to 6 cycles after it rises
    always_ff @(posedge mclk) begin
        p_q <= eye_shift_clock;
        s_q <= rise ? 4'h1 : s_q + 4'(s_q != 4'hf);
        n_q <= stb ? 5'h00 : n_q + 5'(rise);
    end
    a_stb_edge: assert property ($changed(stb) |->
        s_q inside {[4'h2:4'h6]}) else $error("strobe off edge");
    a_bit_edge: assert property ($changed(eye_data) |->
        s_q inside {[4'h2:4'h6]}) else $error("bit off edge");
    a_idle_low: assert property (stb |-> !eye_data)
        else $error("data high idle");
    a_frame_len: assert property ($rose(stb) |-> n_q == 5'h10)
        else $error("frame not 16");
    a_frame_max: assert property (!stb |-> n_q <= 5'h10)
        else $error("frame long");
    a_gap_high: assert property ($rose(stb) |=> stb [*8])
        else $error("gap short");
    a_low_min: assert property ($fell(stb) |-> !stb [*8])
        else $error("frame short");
    cover property ($fell(stb));
    cover property ($rose(stb));
    cover property (rise && !stb);
endmodule
bind eps_serial_out eps_serial_out_checker chk (.*);

// file: test/eps_serial_out_tb.sv
`timescale 1ns/100ps
module eps_serial_out_tb;
    logic mclk = 1'b0, rst_n = 1'b0, eye_shift_clock = 1'b0;
    logic [7:0] sample_x = 8'h00, sample_y = 8'h00;
    logic sample_valid = 1'b0, sample_ready, eye_data, eye_frame_strobe_n;
    logic [15:0] word;
    int nwords, base, err_total, checked;
    logic [31:0] rows [2] = '{32'h0180_8001, 32'ha55a_5aa5};
    eps_serial_out dut (.*);
    eps_eye_rx rx (.*);
    initial forever #5 mclk = ~mclk;
    initial forever #62.5 eye_shift_clock = ~eye_shift_clock;
    task automatic chk(input logic [15:0] a, input logic [15:0] e);
        checked++;
        if (a !== e) begin
            err_total++;
            $display("[FAIL] %0t got %h exp %h", $time, a, e);
        end
    endtask
    task automatic push(input logic [7:0] x, y, input int n);
        for (int i = 0; i < n; i++) begin
            {sample_valid, sample_y, sample_x} = {1'b1, y - 8'(i), x + 8'(i)};
            @(posedge mclk) #1;
        end
        sample_valid = 1'b0;
    endtask
    task automatic take(input logic [15:0] e);
        for (int t = 0; t < 4000 && nwords == base; t++) @(posedge mclk);
        // A word that never arrives counts as a mismatch
        if (nwords == base) begin
            err_total++;
            $display("[FAIL] %0t no word received", $time);
        end
        #1 base = nwords;
        chk(word, e);
    endtask
    task automatic summarize;
        $display("err_total %0d checked %0d", err_total, checked);
        if (err_total == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        #300000 err_total++;
        summarize;
    end
    initial begin
        repeat (12) @(posedge mclk);
        #1 chk({eye_frame_strobe_n, eye_data, sample_ready}, 16'h4);
        rst_n = 1'b1;
        repeat (6) @(posedge mclk);
        #1 base = nwords;
        foreach (rows[i]) begin
            push(rows[i][31:24], rows[i][23:16], 1);
            take(rows[i][15:0]);
        end
        // One word leaves while filling, so 33 fit
        push(8'h10, 8'hef, 33);
        repeat (2) @(posedge mclk);
        #1 chk(16'(sample_ready), 16'h0);
        for (int i = 0; i < 33; i++)
            take({8'hef - 8'(i), 8'h10 + 8'(i)});
        summarize;
    end
endmodule
